// ---- src/rcs_pkg.sv ----
// Constants, register map and command codes of the command sequencer.
// Assumes a 200 MHz system clock and a classic Wishbone register slave.
package rcs_pkg;
	// Command codes
	localparam logic [3:0] RCS_CMD_IDLE   = 4'h0;
	localparam logic [3:0] RCS_CMD_CRC    = 4'h3;
	localparam logic [3:0] RCS_CMD_TX     = 4'h4;
	localparam logic [3:0] RCS_CMD_KEEP   = 4'h7;
	localparam logic [3:0] RCS_CMD_RX     = 4'h8;
	localparam logic [3:0] RCS_CMD_TRX    = 4'hc;
	localparam logic [3:0] RCS_CMD_AUTH   = 4'he;
	localparam logic [3:0] RCS_CMD_SRST   = 4'hf;
	// Register byte addresses
	localparam logic [7:0] RCS_A_CMD      = 8'h00;
	localparam logic [7:0] RCS_A_MODE     = 8'h04;
	localparam logic [7:0] RCS_A_FRAMING  = 8'h08;
	localparam logic [7:0] RCS_A_RXSET    = 8'h0c;
	localparam logic [7:0] RCS_A_IRQ      = 8'h10;
	localparam logic [7:0] RCS_A_ERR      = 8'h14;
	localparam logic [7:0] RCS_A_STAT2    = 8'h18;
	localparam logic [7:0] RCS_A_CRCH     = 8'h1c;
	localparam logic [7:0] RCS_A_CRCL     = 8'h20;
	localparam logic [7:0] RCS_A_FIFO     = 8'h24;
	localparam logic [7:0] RCS_A_FLEVEL   = 8'h28;
	localparam logic [7:0] RCS_A_BAUD     = 8'h2c;
	// Field positions
	localparam int RCS_B_RECEIVER_DISABLE   = 5;
	localparam int RCS_B_SLEEP    = 4;
	localparam int RCS_B_LAUNCH   = 7;
	localparam int RCS_B_MULTI    = 2;
	localparam int RCS_B_WRITE_VIOLATION_FLAG    = 3;
	localparam int RCS_B_PROTERR  = 0;
	localparam int RCS_B_CRYPTO   = 3;
	localparam int RCS_B_COMMAND_DONE_IRQ  = 4;
	localparam int RCS_B_FRAME_RECEIVED_IRQ    = 5;
	localparam int RCS_B_FRAME_SENT_IRQ    = 6;
	localparam int RCS_B_TIMEOUT_IRQ = 0;
	// Reset values
	localparam logic [7:0] RCS_R_MODE     = 8'h3f;
	localparam logic [7:0] RCS_R_BAUD     = 8'heb;
	// Other constants
	localparam int RCS_FIFO_DEPTH = 64;
	localparam int RCS_AUTH_BYTES = 12;
	localparam logic [15:0] RCS_CRC_POLY  = 16'h1021;
endpackage : rcs_pkg

// ---- src/rcs_fifo.sv ----
// Byte FIFO shared by host and command sequencer.
// Assumes single clock; pops and pushes are already qualified.
`timescale 1ns/1ps
module rcs_fifo
	import rcs_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic       push_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       pop_i,
	output logic      [7:0] rdata_o,
	output logic      [6:0] level_o
);
	logic [7:0] mem [RCS_FIFO_DEPTH];
	logic [5:0] wp;
	logic [5:0] rp;
	logic       do_push;
	logic       do_pop;
	assign do_push = push_i && (level_o != 7'(RCS_FIFO_DEPTH));
	assign do_pop  = pop_i && (level_o != 7'h00);
	assign rdata_o = mem[rp];
	always_ff @(posedge ref_clk_i) begin
		if (ce_i && do_push) begin
			mem[wp] <= wdata_i;
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp      <= 6'h00;
			rp      <= 6'h00;
			level_o <= 7'h00;
		end else if (ce_i) begin
			if (do_push) begin
				wp <= wp + 6'h01;
			end
			if (do_pop) begin
				rp <= rp + 6'h01;
			end
			level_o <= level_o + 7'(do_push) - 7'(do_pop);
		end
	end
endmodule : rcs_fifo

// ---- src/rcs_crc.sv ----
// Byte-wide CRC coprocessor, one byte per cycle.
// Assumes the caller loads the seed before feeding bytes.
`timescale 1ns/1ps
module rcs_crc
	import rcs_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic        load_i,
	input  wire logic [15:0] seed_i,
	input  wire logic        feed_i,
	input  wire logic [7:0]  data_i,
	output logic      [15:0] crc_o
);
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ RCS_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_byte
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			crc_o <= 16'h0000;
		end else if (ce_i) begin
			if (load_i) begin
				crc_o <= seed_i;
			end else if (feed_i) begin
				crc_o <= crc_byte(crc_o, data_i);
			end
		end
	end
endmodule : rcs_crc

// ---- src/rcs_sequencer.sv ----
// Command state machine with its Wishbone register file.
// Assumes RF framing, timer and crypto engine handshake on same clock.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module rcs_sequencer
	import rcs_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        tx_done_i,
	input  wire logic        rx_frame_end_i,
	input  wire logic        timer_irq_i,
	input  wire logic        auth_ok_i,
	input  wire logic        auth_fail_i,
	output logic             tx_byte_valid_o,
	output logic      [7:0]  tx_byte_o,
	output logic             tx_active_o,
	output logic             rx_enable_o,
	output logic             auth_start_o,
	output logic      [95:0] auth_params_o
);
	typedef enum logic [7:0] {
		RCS_S_IDLE  = 8'h01,
		RCS_S_CRC   = 8'h02,
		RCS_S_TX    = 8'h04,
		RCS_S_WAIT  = 8'h08,
		RCS_S_RX    = 8'h10,
		RCS_S_AGET  = 8'h20,
		RCS_S_AUTH  = 8'h40,
		RCS_S_TXEND = 8'h80
	} rcs_state_t;

	rcs_state_t  state;
	logic [7:0]  cmd_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  framing;
	logic [7:0]  rx_setup;
	logic [7:0]  irq_reg;
	logic [7:0]  err_reg;
	logic [7:0]  stat2;
	logic [7:0]  baud;
	logic        trx_mode;
	logic [3:0]  acnt;
	logic        srst;
	logic        req;
	logic        wr;
	logic        rd;
	logic        lane0;
	logic        cmd_wr;
	logic        fifo_touch;
	logic        fifo_push;
	logic        fifo_pop;
	logic [7:0]  fifo_q;
	logic [6:0]  fifo_lvl;
	logic        crc_load;
	logic        crc_feed;
	logic [15:0] crc_val;
	logic        self_done;

	// Wishbone decode
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr    = req && wb_we_i;
	assign rd    = req && !wb_we_i;
	assign lane0 = wb_sel_i[0];

	function automatic logic mapped(input logic [7:0] a);
		return (a <= RCS_A_BAUD) && (a[1:0] == 2'b00);
	endfunction : mapped

	assign cmd_wr     = ce_i && wr && lane0 && (wb_adr_i == RCS_A_CMD)
	                  && (wb_dat_i[3:0] != RCS_CMD_KEEP);
	assign fifo_touch = ce_i && req && (wb_adr_i == RCS_A_FIFO);
	assign fifo_push  = fifo_touch && wb_we_i && lane0 && (state != RCS_S_AUTH)
	                  && (state != RCS_S_AGET);
	assign crc_feed   = (state == RCS_S_CRC) && (fifo_lvl != 7'h00) && !cmd_wr;
	assign crc_load   = cmd_wr && (wb_dat_i[3:0] == RCS_CMD_CRC);
	assign fifo_pop   = ce_i && (crc_feed
	                  || ((state == RCS_S_TX) && (fifo_lvl != 7'h00))
	                  || ((state == RCS_S_AGET) && (fifo_lvl != 7'h00))
	                  || (rd && (wb_adr_i == RCS_A_FIFO) && (state != RCS_S_AUTH)
	                      && (state != RCS_S_AGET)));
	assign srst = cmd_wr && (wb_dat_i[3:0] == RCS_CMD_SRST);
	assign self_done = ((state == RCS_S_TXEND) && tx_done_i && !trx_mode)
	                 || ((state == RCS_S_RX) && rx_frame_end_i && !trx_mode
	                     && !rx_setup[RCS_B_MULTI])
	                 || ((state == RCS_S_AUTH) && auth_ok_i);

	rcs_fifo u_fifo (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.push_i    (fifo_push),
		.wdata_i   (wb_dat_i[7:0]),
		.pop_i     (fifo_pop),
		.rdata_o   (fifo_q),
		.level_o   (fifo_lvl)
	);

	rcs_crc u_crc (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.load_i    (crc_load),
		.seed_i    (seed_of(mode_reg[1:0])),
		.feed_i    (crc_feed),
		.data_i    (fifo_q),
		.crc_o     (crc_val)
	);

	function automatic logic [15:0] seed_of(input logic [1:0] s);
		case (s)
			2'b00: return 16'h0000;
			2'b01: return 16'h6363;
			2'b10: return 16'ha671;
			default: return 16'hffff;
		endcase
	endfunction : seed_of

	// Bus answer
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req && mapped(wb_adr_i);
			wb_err_o <= req && !mapped(wb_adr_i);
			wb_dat_o <= 32'h0000_0000;
			if (rd) begin
				case (wb_adr_i)
					RCS_A_CMD:     wb_dat_o[7:0] <= cmd_reg;
					RCS_A_MODE:    wb_dat_o[7:0] <= mode_reg;
					RCS_A_FRAMING: wb_dat_o[7:0] <= framing;
					RCS_A_RXSET:   wb_dat_o[7:0] <= rx_setup;
					RCS_A_IRQ:     wb_dat_o[7:0] <= irq_reg;
					RCS_A_ERR:     wb_dat_o[7:0] <= err_reg;
					RCS_A_STAT2:   wb_dat_o[7:0] <= stat2;
					RCS_A_CRCH:    wb_dat_o[7:0] <= crc_val[15:8];
					RCS_A_CRCL:    wb_dat_o[7:0] <= crc_val[7:0];
					RCS_A_FIFO:    wb_dat_o[7:0] <= fifo_q;
					RCS_A_FLEVEL:  wb_dat_o[6:0] <= fifo_lvl;
					RCS_A_BAUD:    wb_dat_o[7:0] <= baud;
					default:       wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Command register
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_reg <= 8'h00;
		end else if (ce_i) begin
			if (srst) begin
				cmd_reg <= 8'h00;
			end else if (wr && lane0 && (wb_adr_i == RCS_A_CMD)) begin
				if (wb_dat_i[3:0] == RCS_CMD_KEEP) begin
					cmd_reg <= {wb_dat_i[7:4], cmd_reg[3:0]};
				end else begin
					cmd_reg <= wb_dat_i[7:0];
				end
			end else if (self_done || (cmd_reg[3:0] == RCS_CMD_IDLE)) begin
				cmd_reg[3:0] <= RCS_CMD_IDLE;
			end
		end
	end

	// Config registers
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_reg <= RCS_R_MODE;
			framing  <= 8'h00;
			rx_setup <= 8'h00;
			baud     <= RCS_R_BAUD;
		end else if (ce_i) begin
			if (srst) begin
				mode_reg <= RCS_R_MODE;
				framing  <= 8'h00;
				rx_setup <= 8'h00;
				baud     <= RCS_R_BAUD;
			end else begin
				if (wr && lane0 && (wb_adr_i == RCS_A_MODE)) begin
					mode_reg <= wb_dat_i[7:0];
				end
				if (wr && lane0 && (wb_adr_i == RCS_A_RXSET)) begin
					rx_setup <= wb_dat_i[7:0];
				end
				if (wr && lane0 && (wb_adr_i == RCS_A_BAUD)) begin
					baud <= wb_dat_i[7:0];
				end
				if (wr && lane0 && (wb_adr_i == RCS_A_FRAMING)) begin
					framing <= wb_dat_i[7:0];
				end else if (state == RCS_S_WAIT && framing[RCS_B_LAUNCH]) begin
					framing[RCS_B_LAUNCH] <= 1'b0;
				end
			end
		end
	end

	// Command state machine
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state    <= RCS_S_IDLE;
			trx_mode <= 1'b0;
			acnt     <= 4'h0;
		end else if (ce_i) begin
			if (cmd_wr) begin
				acnt     <= 4'h0;
				trx_mode <= (wb_dat_i[3:0] == RCS_CMD_TRX);
				case (wb_dat_i[3:0])
					RCS_CMD_CRC:  state <= RCS_S_CRC;
					RCS_CMD_TX:   state <= RCS_S_TX;
					RCS_CMD_RX:   state <= RCS_S_RX;
					RCS_CMD_TRX:  state <= RCS_S_WAIT;
					RCS_CMD_AUTH: state <= RCS_S_AGET;
					default:      state <= RCS_S_IDLE;
				endcase
			end else begin
				case (state)
					RCS_S_CRC: state <= RCS_S_CRC;
					RCS_S_TX: begin
						if (fifo_lvl == 7'h00) begin
							state <= RCS_S_TXEND;
						end
					end
					RCS_S_TXEND: begin
						if (tx_done_i) begin
							state <= trx_mode ? RCS_S_RX : RCS_S_IDLE;
						end
					end
					RCS_S_WAIT: begin
						if (framing[RCS_B_LAUNCH]) begin
							state <= RCS_S_TX;
						end
					end
					RCS_S_RX: begin
						if (rx_frame_end_i && !rx_setup[RCS_B_MULTI]) begin
							state <= trx_mode ? RCS_S_WAIT : RCS_S_IDLE;
						end
					end
					RCS_S_AGET: begin
						if (fifo_lvl != 7'h00) begin
							acnt <= acnt + 4'h1;
							if (acnt == 4'(RCS_AUTH_BYTES - 1)) begin
								state <= RCS_S_AUTH;
							end
						end
					end
					RCS_S_AUTH: begin
						if (auth_ok_i || auth_fail_i) begin
							state <= RCS_S_IDLE;
						end
					end
					default: state <= RCS_S_IDLE;
				endcase
			end
		end
	end

	// Parameter capture
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			auth_params_o <= 96'h0;
		end else if (ce_i && state == RCS_S_AGET && fifo_lvl != 7'h00) begin
			auth_params_o <= {auth_params_o[87:0], fifo_q};
		end
	end

	// Link outputs
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_byte_valid_o <= 1'b0;
			tx_byte_o       <= 8'h00;
			tx_active_o     <= 1'b0;
			rx_enable_o     <= 1'b0;
			auth_start_o    <= 1'b0;
		end else if (ce_i) begin
			tx_byte_valid_o <= (state == RCS_S_TX) && (fifo_lvl != 7'h00) && !cmd_wr;
			tx_byte_o       <= fifo_q;
			tx_active_o     <= (state == RCS_S_TX) || (state == RCS_S_TXEND);
			rx_enable_o     <= (state == RCS_S_RX) && !cmd_reg[RCS_B_RECEIVER_DISABLE];
			auth_start_o    <= (state == RCS_S_AGET) && (acnt == 4'(RCS_AUTH_BYTES - 1))
			                && (fifo_lvl != 7'h00) && !cmd_wr;
		end
	end

	// Flags: hardware set wins over host clear; soft reset clears all
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_reg <= 8'h00;
			err_reg <= 8'h00;
			stat2   <= 8'h00;
		end else if (ce_i) begin
			if (srst) begin
				irq_reg <= 8'h00;
				err_reg <= 8'h00;
				stat2   <= 8'h00;
			end else begin
				if (wr && lane0 && (wb_adr_i == RCS_A_IRQ)) begin
					irq_reg <= irq_reg & ~wb_dat_i[7:0];
				end
				if (wr && lane0 && (wb_adr_i == RCS_A_ERR)) begin
					err_reg <= err_reg & ~wb_dat_i[7:0];
				end
				if (wr && lane0 && (wb_adr_i == RCS_A_STAT2)) begin
					stat2[RCS_B_CRYPTO] <= wb_dat_i[RCS_B_CRYPTO];
				end
				if (self_done || (cmd_wr && (wb_dat_i[3:0] == RCS_CMD_IDLE))) begin
					irq_reg[RCS_B_COMMAND_DONE_IRQ] <= 1'b1;
				end
				if (timer_irq_i) begin
					irq_reg[RCS_B_TIMEOUT_IRQ] <= 1'b1;
				end
				if (state != RCS_S_AUTH && state != RCS_S_AGET) begin
					if (state == RCS_S_TXEND && tx_done_i) begin
						irq_reg[RCS_B_FRAME_SENT_IRQ] <= 1'b1;
					end
					if (state == RCS_S_RX && rx_frame_end_i) begin
						irq_reg[RCS_B_FRAME_RECEIVED_IRQ] <= 1'b1;
					end
				end
				if (fifo_touch && (state == RCS_S_AUTH || state == RCS_S_AGET)) begin
					err_reg[RCS_B_WRITE_VIOLATION_FLAG] <= 1'b1;
				end
				if (state == RCS_S_AUTH && auth_ok_i) begin
					stat2[RCS_B_CRYPTO] <= 1'b1;
				end
				if (state == RCS_S_AUTH && auth_fail_i) begin
					err_reg[RCS_B_PROTERR] <= 1'b1;
					stat2[RCS_B_CRYPTO]    <= 1'b0;
				end
			end
		end
	end

	// p_rx_done: receive ends at frame end
	sequence s_rx_end;
		ce_i && state == RCS_S_RX && rx_frame_end_i && !rx_setup[RCS_B_MULTI] && !trx_mode
		&& !cmd_wr;
	endsequence
	property p_rx_done;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		s_rx_end |=> state == RCS_S_IDLE;
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("receive did not end");
	property p_multi;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && state == RCS_S_RX && rx_setup[RCS_B_MULTI] && !cmd_wr |=> state == RCS_S_RX;
	endproperty
	a_multi: assert property (p_multi) else $error("multi receive left");
	property p_write_violation_flag;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		fifo_touch && state == RCS_S_AUTH && !srst |=> err_reg[RCS_B_WRITE_VIOLATION_FLAG];
	endproperty
	a_write_violation_flag: assert property (p_write_violation_flag) else $error("write error missing");
	property p_crc_stay;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && state == RCS_S_CRC && !cmd_wr |=> state == RCS_S_CRC;
	endproperty
	a_crc_stay: assert property (p_crc_stay) else $error("crc ended alone");
	property p_keep;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && wr && lane0 && wb_adr_i == RCS_A_CMD && wb_dat_i[3:0] == RCS_CMD_KEEP
		&& !self_done |=> $stable(cmd_reg[3:0]) && $stable(state);
	endproperty
	a_keep: assert property (p_keep) else $error("keep code changed command");
	property p_prot;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && state == RCS_S_AUTH && auth_fail_i && !srst
		|=> err_reg[RCS_B_PROTERR] && !stat2[RCS_B_CRYPTO];
	endproperty
	a_prot: assert property (p_prot) else $error("auth fault not flagged");
	property p_done;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && self_done && !wr |=> irq_reg[RCS_B_COMMAND_DONE_IRQ] && cmd_reg[3:0] == RCS_CMD_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("done not reported");
	property p_nolaunch;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && state == RCS_S_WAIT && !framing[RCS_B_LAUNCH] && !cmd_wr
		|=> state == RCS_S_WAIT;
	endproperty
	a_nolaunch: assert property (p_nolaunch) else $error("sent without launch");
endmodule : rcs_sequencer

// ---- verif/rcs_rf_model.sv ----
// Behavioural RF framer and authentication engine facing the sequencer.
// Assumes the sequencer clock; every answer is a one-cycle pulse.
`timescale 1ns/1ps
module rcs_rf_model #(
	parameter int RX_GAP   = 12,
	parameter int AUTH_DLY = 24
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic tx_byte_valid_i,
	input  wire logic tx_active_i,
	input  wire logic rx_enable_i,
	input  wire logic auth_start_i,
	input  wire logic auth_bad_i,
	output logic      tx_done_o,
	output logic      rx_frame_end_o,
	output logic      auth_ok_o,
	output logic      auth_fail_o
);
	int   tx_idle;
	int   rx_cnt;
	int   au_cnt;
	logic sent;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_idle        <= 0;
			rx_cnt         <= 0;
			au_cnt         <= 0;
			sent           <= 1'b0;
			tx_done_o      <= 1'b0;
			rx_frame_end_o <= 1'b0;
			auth_ok_o      <= 1'b0;
			auth_fail_o    <= 1'b0;
		end else begin
			tx_done_o <= sent && tx_idle == 3;
			sent      <= tx_active_i && (sent || tx_byte_valid_i);
			tx_idle   <= (!tx_active_i || tx_byte_valid_i) ? 0 : (tx_idle < 4 ? tx_idle + 1 : 4);
			rx_frame_end_o <= rx_enable_i && rx_cnt == RX_GAP - 1;
			rx_cnt         <= (rx_enable_i && rx_cnt < RX_GAP - 1) ? rx_cnt + 1 : 0;
			au_cnt      <= auth_start_i ? AUTH_DLY : (au_cnt > 0 ? au_cnt - 1 : 0);
			auth_ok_o   <= au_cnt == 1 && !auth_bad_i;
			auth_fail_o <= au_cnt == 1 && auth_bad_i;
		end
	end
endmodule : rcs_rf_model

// ---- verif/reader_command_sequencer_tb.sv ----
// Self-checking random bench of the command sequencer.
// Assumes the sequencer with its FIFO and CRC, and the RF partner model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module reader_command_sequencer_tb;
	import rcs_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic        cyc       = 1'b0;
	logic        stb       = 1'b0;
	logic        we        = 1'b0;
	logic        tmr       = 1'b0;
	logic        auth_bad  = 1'b0;
	logic [7:0]  adr       = 8'h00;
	logic [31:0] wdat      = 32'h0;
	logic [31:0] rdat;
	logic        ack, err, er, tx_v, tx_a, rx_en, au_st, tx_d, rx_fe, au_ok, au_f;
	logic [7:0]  rd, tx_b;
	logic [95:0] au_p, au_exp;
	logic [15:0] crc;
	logic [7:0]  txq[$];
	logic [7:0]  expq[$];
	logic [15:0] seeds[4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
	int          n_fail   = 0;
	int          n_checks = 0;

	rcs_sequencer dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .tx_done_i(tx_d),
		.rx_frame_end_i(rx_fe), .timer_irq_i(tmr), .auth_ok_i(au_ok), .auth_fail_i(au_f),
		.tx_byte_valid_o(tx_v), .tx_byte_o(tx_b), .tx_active_o(tx_a), .rx_enable_o(rx_en),
		.auth_start_o(au_st), .auth_params_o(au_p));
	rcs_rf_model rf_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tx_byte_valid_i(tx_v),
		.tx_active_i(tx_a), .rx_enable_i(rx_en), .auth_start_i(au_st), .auth_bad_i(auth_bad),
		.tx_done_o(tx_d), .rx_frame_end_o(rx_fe), .auth_ok_o(au_ok), .auth_fail_o(au_f));

	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (tx_v) txq.push_back(tx_b);

	function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ RCS_CRC_POLY) : (c << 1);
		return c;
	endfunction : crc_f

	task automatic results();
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		@(posedge ref_clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		t = 0;
		do begin
			@(posedge ref_clk_i);
			t++;
		end while (!(ack || err) && t < 50);
		if (t == 50) n_fail++;
		rd = rdat[7:0];
		er = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(rd, e)
	endtask : rdc

	task automatic rdb(input logic [7:0] a, input int b, input logic e);
		bus(1'b0, a, 8'h00);
		`CHK(rd[b], e)
	endtask : rdb

	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, a, 8'h00);
			if ((rd & m) === e) break;
		end
		`CHK(rd & m, e)
	endtask : poll

	task automatic push(input int n);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			expq.push_back(b);
			wr(RCS_A_FIFO, b);
		end
	endtask : push

	task automatic cmpq();
		`CHK(txq.size(), expq.size())
		foreach (expq[i]) `CHK(txq[i], expq[i])
	endtask : cmpq

	initial begin
		#100000;
		n_fail++;
		results();
	end

	initial begin
		void'($urandom(32'h1103));
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		rdc(RCS_A_MODE, RCS_R_MODE);
		rdc(RCS_A_BAUD, RCS_R_BAUD);
		bus(1'b0, 8'h80, 8'h00);
		`CHK(er, 1'b1)
		for (int s = 0; s < 4; s++) begin
			wr(RCS_A_MODE, 8'(s));
			expq.delete();
			push(1 + $urandom % 6);
			wr(RCS_A_CMD, {4'h0, RCS_CMD_CRC});
			push(1);
			poll(RCS_A_FLEVEL, 8'hff, 8'h00);
			crc = seeds[s];
			foreach (expq[i]) crc = crc_f(crc, expq[i]);
			rdc(RCS_A_CRCH, crc[15:8]);
			rdc(RCS_A_CRCL, crc[7:0]);
			rdc(RCS_A_CMD, {4'h0, RCS_CMD_CRC});
			wr(RCS_A_CMD, {4'h2, RCS_CMD_KEEP});
			rdc(RCS_A_CMD, {4'h2, RCS_CMD_CRC});
			wr(RCS_A_IRQ, 8'hff);
			wr(RCS_A_CMD, {4'h0, RCS_CMD_IDLE});
			poll(RCS_A_CMD, 8'h0f, 8'h00);
			rdb(RCS_A_IRQ, RCS_B_COMMAND_DONE_IRQ, 1'b1);
		end
		for (int k = 0; k < 2; k++) begin
			expq.delete();
			txq.delete();
			push(k == 0 ? 1 : 2 + $urandom % 20);
			wr(RCS_A_IRQ, 8'hff);
			wr(RCS_A_CMD, {4'h0, RCS_CMD_TX});
			poll(RCS_A_CMD, 8'h0f, 8'h00);
			cmpq();
			rdb(RCS_A_IRQ, RCS_B_COMMAND_DONE_IRQ, 1'b1);
		end
		wr(RCS_A_RXSET, 8'h00);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_RX});
		@(posedge ref_clk_i);
		`CHK(rx_en, 1'b1)
		poll(RCS_A_CMD, 8'h0f, 8'h00);
		wr(RCS_A_RXSET, 8'h04);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_RX});
		repeat (40) @(posedge ref_clk_i);
		rdc(RCS_A_CMD, {4'h0, RCS_CMD_RX});
		wr(RCS_A_CMD, {4'h2, RCS_CMD_KEEP});
		@(posedge ref_clk_i);
		`CHK(rx_en, 1'b0)
		tmr <= 1'b1;
		@(posedge ref_clk_i);
		tmr <= 1'b0;
		rdb(RCS_A_IRQ, RCS_B_TIMEOUT_IRQ, 1'b1);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_IDLE});
		wr(RCS_A_RXSET, 8'h00);
		expq.delete();
		txq.delete();
		push(3);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_TRX});
		repeat (20) @(posedge ref_clk_i);
		`CHK(txq.size(), 0)
		wr(RCS_A_FRAMING, 8'h80);
		repeat (60) @(posedge ref_clk_i);
		cmpq();
		rdc(RCS_A_CMD, {4'h0, RCS_CMD_TRX});
		rdb(RCS_A_FRAMING, RCS_B_LAUNCH, 1'b0);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_IDLE});
		for (int k = 0; k < 2; k++) begin
			auth_bad <= k[0];
			expq.delete();
			expq.push_back(k[0] ? 8'h61 : 8'h60);
			wr(RCS_A_FIFO, expq[0]);
			push(RCS_AUTH_BYTES - 1);
			foreach (expq[i]) au_exp = {au_exp[87:0], expq[i]};
			wr(RCS_A_ERR, 8'hff);
			wr(RCS_A_IRQ, 8'hff);
			wr(RCS_A_CMD, {4'h0, RCS_CMD_AUTH});
			for (int i = 0; i < 40 && au_st !== 1'b1; i++) @(posedge ref_clk_i);
			`CHK(au_p, au_exp)
			wr(RCS_A_FIFO, 8'h55);
			rdb(RCS_A_ERR, RCS_B_WRITE_VIOLATION_FLAG, 1'b1);
			rdc(RCS_A_FLEVEL, 8'h00);
			rdb(RCS_A_IRQ, RCS_B_FRAME_SENT_IRQ, 1'b0);
			if (k[0]) begin
				repeat (30) @(posedge ref_clk_i);
				wr(RCS_A_CMD, {4'h0, RCS_CMD_IDLE});
			end
			poll(RCS_A_CMD, 8'h0f, 8'h00);
			rdb(RCS_A_STAT2, RCS_B_CRYPTO, !k[0]);
			rdb(RCS_A_ERR, RCS_B_PROTERR, k[0]);
		end
		wr(RCS_A_MODE, 8'h00);
		wr(RCS_A_BAUD, 8'h00);
		expq.delete();
		push(2);
		wr(RCS_A_CMD, {4'h0, RCS_CMD_SRST});
		poll(RCS_A_CMD, 8'h0f, 8'h00);
		rdc(RCS_A_MODE, RCS_R_MODE);
		rdc(RCS_A_BAUD, RCS_R_BAUD);
		rdc(RCS_A_FLEVEL, 8'h02);
		rdc(RCS_A_FIFO, expq[0]);
		results();
	end
endmodule : reader_command_sequencer_tb
